// [hdl/temp_seq_pkg.sv]
// constants for the temperature autoconvert sequencer
package temp_seq_pkg;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned CONV_INTERVAL_US = 350;
  localparam int unsigned CONV_TIME_US = 25;
  localparam int unsigned INTERVAL_CYCLES = CONV_INTERVAL_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned CONV_CYCLES = CONV_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 17;
  localparam int unsigned RESULT_W = 10;
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned BITCNT_W = 5;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 10'h000;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01
  } conv_state_t;
endpackage : temp_seq_pkg

// [hdl/sync2.sv]
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module sync2 #(
  parameter logic RESET_VAL = 1'b0
)
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // async level in, synced level out
  input wire logic i_async,
  output logic o_sync
);
  logic meta_reg;
  logic sync_reg;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end
    else if (i_clk_en)
    begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;
endmodule : sync2

// [hdl/temp_autoconvert_lockout.sv]
// temperature sensor autoconvert sequencer with access lockout and serial read
`timescale 1ns/10ps
module temp_autoconvert_lockout
  import temp_seq_pkg::*;
(
  // clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // serial pins
  input wire logic i_temp_select_n,
  input wire logic i_sclk,
  input wire logic i_din,
  output logic o_dout,
  output logic o_dout_oe,
  // analog front end sample, two's complement
  input wire logic [RESULT_W-1:0] i_adc_value,
  // status
  output logic o_converting,
  output logic o_lockout,
  output logic [RESULT_W-1:0] o_result
);
  ////////////////////////////////////////////////////////////////////////////
  logic sel_n_s;
  logic sclk_s;

  sync2 #(.RESET_VAL(1'b1)) u_sync_sel (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_async(i_temp_select_n),
    .o_sync(sel_n_s)
  );

  sync2 #(.RESET_VAL(1'b0)) u_sync_sclk (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_async(i_sclk),
    .o_sync(sclk_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // edge detection on synchronised pins
  logic sel_n_d_reg;
  logic sclk_d_reg;
  logic sel_fall;
  logic sel_rise;
  logic sclk_fall;

  assign sel_fall = sel_n_d_reg & ~sel_n_s;
  assign sel_rise = ~sel_n_d_reg & sel_n_s;
  assign sclk_fall = sclk_d_reg & ~sclk_s & ~sel_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer state
  conv_state_t state_reg;
  conv_state_t state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic lock_reg;
  logic lock_next;
  logic [RESULT_W-1:0] result_reg;
  logic [RESULT_W-1:0] result_next;
  logic conv_start;

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    lock_next = lock_reg;
    result_next = result_reg;
    conv_start = 1'b0;
    unique case (state_reg)
      ST_IDLE:
      begin
        if (cnt_reg >= CNT_W'(INTERVAL_CYCLES - 1))
        begin
          conv_start = 1'b1;
          state_next = ST_CONV;
          cnt_next = '0;
        end
        else
        begin
          cnt_next = cnt_reg + CNT_W'(1);
        end
      end
      ST_CONV:
      begin
        if (cnt_reg >= CNT_W'(CONV_CYCLES - 1))
        begin
          if (!lock_reg)
          begin
            result_next = i_adc_value;
          end
          state_next = ST_IDLE;
          cnt_next = '0;
        end
        else
        begin
          cnt_next = cnt_reg + CNT_W'(1);
        end
      end
      default:
      begin
        state_next = ST_IDLE;
        cnt_next = '0;
      end
    endcase
    // clear only at conversion start, kept if selected
    if (conv_start)
    begin
      lock_next = ~sel_n_s;
    end
    if (state_reg == ST_CONV && (sel_fall || !sel_n_s))
    begin
      lock_next = 1'b1;
    end
    // start a conversion at end of access; result loads only if lockout is clear
    if (sel_rise)
    begin
      state_next = ST_CONV;
      cnt_next = '0;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      lock_reg <= 1'b0;
      result_reg <= RESULT_RESET;
    end
    else if (i_clk_en)
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      lock_reg <= lock_next;
      result_reg <= result_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial shifter: frame of sixteen clocks
  logic [FRAME_BITS-1:0] shift_reg;
  logic [FRAME_BITS-1:0] shift_next;
  logic [BITCNT_W-1:0] bit_reg;
  logic [BITCNT_W-1:0] bit_next;
  logic dout_reg;
  logic dout_next;
  logic oe_reg;
  logic oe_next;

  always_comb
  begin
    shift_next = shift_reg;
    bit_next = bit_reg;
    dout_next = dout_reg;
    oe_next = ~sel_n_s;
    if (sel_fall)
    begin
      // leading zero then sign first, padded low
      shift_next = {1'b0, result_reg, 5'h00};
      bit_next = '0;
      dout_next = 1'b0;
    end
    else if (sclk_fall && bit_reg < BITCNT_W'(FRAME_BITS))
    begin
      shift_next = {shift_reg[FRAME_BITS-2:0], 1'b0};
      bit_next = bit_reg + BITCNT_W'(1);
      // hold last data bit after ten bits
      if (bit_reg < BITCNT_W'(RESULT_W))
      begin
        dout_next = shift_reg[FRAME_BITS-2];
      end
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      shift_reg <= '0;
      bit_reg <= '0;
      dout_reg <= 1'b0;
      oe_reg <= 1'b0;
      sel_n_d_reg <= 1'b1;
      sclk_d_reg <= 1'b0;
    end
    else if (i_clk_en)
    begin
      shift_reg <= shift_next;
      bit_reg <= bit_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      sel_n_d_reg <= sel_n_s;
      sclk_d_reg <= sclk_s;
    end
  end

  assign o_dout = dout_reg;
  assign o_dout_oe = oe_reg;
  assign o_converting = (state_reg == ST_CONV);
  assign o_lockout = lock_reg;
  assign o_result = result_reg;
endmodule : temp_autoconvert_lockout

// [dv/temp_lockout_chk_assertions.sv]
// assertions on the temperature sequencer ports
`timescale 1ns/10ps
module temp_lockout_chk
  import temp_seq_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_temp_select_n,
  input wire logic [RESULT_W-1:0] i_adc_value,
  input wire logic o_dout_oe,
  input wire logic o_converting,
  input wire logic o_lockout,
  input wire logic [RESULT_W-1:0] o_result
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  AST_HOLD: assert property (!$stable(o_result) |-> $fell(o_converting))
    else $error("result moved");
  AST_LOAD: assert property ($fell(o_converting) && !o_lockout |-> o_result == i_adc_value)
    else $error("no load");
  AST_BLOCK: assert property ($fell(o_converting) && o_lockout |-> $stable(o_result))
    else $error("locked load");
  AST_SET: assert property ((o_converting && !i_temp_select_n)[*5] |-> o_lockout)
    else $error("no lockout");
  AST_CLEAR: assert property (o_lockout |=> o_lockout || $rose(o_converting))
    else $error("early clear");
  AST_KEEP: assert property ($rose(o_converting) && !i_temp_select_n
    && !$past(i_temp_select_n, 4) |-> o_lockout) else $error("lockout lost");
  AST_RESTART: assert property ($rose(i_temp_select_n) |-> ##[2:6] o_converting ##1 o_converting[*8])
    else $error("no restart");
  AST_OE: assert property ((!i_temp_select_n)[*5] |-> o_dout_oe)
    else $error("no drive");
  CVR_LOCK: cover property ($rose(o_lockout));
  CVR_CONV: cover property ($fell(o_converting));
  CVR_OE: cover property ($rose(o_dout_oe));
endmodule : temp_lockout_chk

// [dv/temp_host_model.sv]
// serial host model reading the temperature sensor
`timescale 1ns/10ps
module temp_host_model (
  input wire logic i_sys_clk,
  input wire logic i_dout,
  output logic o_select_n,
  output logic o_sclk,
  output logic o_din
);
  initial
  begin
    o_select_n = 1'b1;
    o_sclk = 1'b1;
    o_din = 1'b0;
  end
  task automatic half;
    repeat (16) @(posedge i_sys_clk);
  endtask : half
  task automatic frame(input bit keep, output logic [10:0] v);
    o_select_n <= 1'b0;
    half();
    for (int i = 0; i < 16; i++)
    begin
      if (i < 11)
        v[10-i] = i_dout;
      o_sclk <= 1'b0;
      half();
      o_sclk <= 1'b1;
      half();
    end
    o_select_n <= !keep;
  endtask : frame
endmodule : temp_host_model

// [dv/tb_temp_autoconvert_lockout.sv]
// bench for the temperature sequencer
`timescale 1ns/10ps
module tb_temp_autoconvert_lockout;
  import temp_seq_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [RESULT_W-1:0] adc = 10'h360;
  logic sel_n, sclk, din, dout, oe, conv, lock;
  logic [RESULT_W-1:0] res;
  logic [10:0] rd;
  int n_fail = 0;
  int check_count = 0;
  always #2.5 clk = ~clk;
  temp_autoconvert_lockout dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_clk_en(1'b1),
    .i_temp_select_n(sel_n), .i_sclk(sclk), .i_din(din), .o_dout(dout), .o_dout_oe(oe),
    .i_adc_value(adc), .o_converting(conv), .o_lockout(lock), .o_result(res));
  temp_host_model host (.i_sys_clk(clk), .i_dout(dout), .o_select_n(sel_n), .o_sclk(sclk),
    .o_din(din));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task automatic wait_conv(input logic v, output int n);
    n = 0;
    while (conv !== v && n < 80000)
    begin
      // sample the registered flag away from the edge that launches it
      @(negedge clk);
      n++;
    end
    @(posedge clk);
  endtask : wait_conv
  task automatic t_read;
    int n;
    host.frame(1'b0, rd);
    check(rd, 0);
    wait_conv(1'b1, n);
    check(n < 8, 1);
    wait_conv(1'b0, n);
    check(n, CONV_CYCLES);
    check(res, 10'h360);
    adc <= 10'h064;
    host.frame(1'b0, rd);
    check(rd, 11'h360);
    check(lock, 0);
  endtask : t_read
  task automatic t_lock;
    int n;
    wait_conv(1'b1, n);
    host.frame(1'b1, rd);
    check(lock, 1);
    check(rd, 11'h360);
    wait_conv(1'b0, n);
    check(res, 10'h360);
    wait_conv(1'b1, n);
    check(n >= INTERVAL_CYCLES - 2 && n <= INTERVAL_CYCLES + 2, 1);
    check(lock, 1);
  endtask : t_lock
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_read();
    t_lock();
    end_of_test();
  end
  initial
  begin
    #450000;
    n_fail++;
    end_of_test();
  end
endmodule : tb_temp_autoconvert_lockout
bind temp_autoconvert_lockout temp_lockout_chk chk (.i_sys_clk, .i_sys_rst, .i_temp_select_n,
  .i_adc_value, .o_dout_oe, .o_converting, .o_lockout, .o_result);
